// >>> pkg/mcount_pkg.sv
/*
  Constants, field layout and carrier types for the modulus counter block.
  Assumes one 10 MHz core clock and a plain strobe register port.
*/
package mcount_pkg;
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_CSC = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CNT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_RLD = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RSV = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_ICLR = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_IEN = 4'hc;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // ----------------------------------------
  // Status/control field positions
  // ----------------------------------------
  localparam int B_OVF = 15;
  localparam int B_IL_HI = 14;
  localparam int B_IL_LO = 12;
  localparam int B_ARB = 11;
  localparam int B_DRV_A = 9;
  localparam int B_DRV_B = 8;
  localparam int B_CLK_LVL = 7;
  localparam int B_LOAD_LVL = 6;
  localparam int B_NEG = 5;
  localparam int B_POS = 4;
  localparam int B_SEL_HI = 2;
  localparam int B_SEL_LO = 0;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam int TAPS = 6;
  localparam logic [2:0] SEL_EXT_FALL = 3'h6;
  localparam logic [2:0] SEL_EXT_RISE = 3'h7;
  localparam logic [2:0] IL_OFF = 3'h0;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] RLD_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam int N_EVT = 2;
  localparam int EVT_OVF = 0;
  localparam int EVT_LOAD = 1;
endpackage : mcount_pkg

// >>> hw/tap_divider.sv
/*
  Free-running divider giving one-cycle enable pulses at /2, /4 .. /2^TAPS.
  Assumes a single core clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module tap_divider #(
  parameter int TAPS = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Tap enables
  output logic [TAPS-1:0] tap_en
);
  logic [TAPS-1:0] div_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Tap k fires when the low k+1 bits are all ones
  // ----------------------------------------
  genvar k;
  generate
    for (k = 0; k < TAPS; k++) begin : g_tap
      assign tap_en[k] = &div_r[k:0];
    end
  endgenerate
endmodule : tap_divider

// >>> hw/pin_edge.sv
/*
  Two-flop synchroniser with rise and fall detection for one input pin.
  Assumes the pin changes no faster than a quarter of the core clock.
*/
`timescale 1ns/1ps
module pin_edge (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pin
  input wire logic pin,
  // Synchronised view
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic hist_r;
  logic primed_r;

  // Chain is not reset so the level keeps tracking the pin
  always_ff @(posedge core_clk) begin
    meta_r <= pin;
    sync_r <= meta_r;
    hist_r <= sync_r;
  end

  // No edge reported until history holds a real sample
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primed_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
    end
  end

  assign level = sync_r;
  assign rise = primed_r & sync_r & ~hist_r;
  assign fall = primed_r & ~sync_r & hist_r;
endmodule : pin_edge

// >>> hw/modulus_counter.sv
/*
  Modulus counter: 16-bit up-counter with reload, pin load, bus drive
  and overflow interrupt. Assumes asynchronous pins and a strobe register port.
*/
// Implementation choices: the address-and-strobe port and the register offsets.
// How it works
// - Status bit 11 plus three bus-side bits form the interrupt arbitration id.
// - Bits 9:8 choose which time base buses carry the count.
// - Bit 7 reads count pin level; writes ignored, reset leaves it alone.
// - Bit 6 reads load pin level; writes ignored, reset leaves it alone.
// - Bits 5:4 pick load edges: none, rising, falling or both.
// - Clock select: codes 0-5 prescaler taps, 6 falling, 7 rising pin edges.
// - Counter value is readable, writable, sixteen bits, cleared by reset.
// - Separate reload value register feeds overflow and load events.
// - Rollover from all ones loads reload value and sets overflow flag.
// - Flag clears on read-one then write-zero, unless overflow came between.
// - Level field gives priority; zero disables the interrupt request.
// - Reserved bits and locations read zero and ignore writes.
`timescale 1ns/1ps
module modulus_counter
  import mcount_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire reg_req_s req,
  output logic [DATA_W-1:0] rdata,
  // Pins
  input wire logic count_input_pin,
  input wire logic load_input_pin,
  // Time base buses
  output logic [15:0] tbb_a_val,
  output logic tbb_a_drv,
  output logic [15:0] tbb_b_val,
  output logic tbb_b_drv,
  // Intermodule bus interrupt
  input wire logic [2:0] arb_id_low,
  output logic imb_irq_req,
  output logic [2:0] imb_irq_level,
  output logic [3:0] arbitration_id,
  // Local interrupt
  output logic irq
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] rld_r;
  logic ovf_r;
  logic ovf_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [2:0] il_r;
  logic arb_msb_r;
  logic drv_a_r;
  logic drv_b_r;
  logic neg_en_r;
  logic pos_en_r;
  logic [2:0] sel_r;
  logic [N_EVT-1:0] istat_r;
  logic [N_EVT-1:0] istat_nxt;
  logic [N_EVT-1:0] ien_r;
  logic [DATA_W-1:0] rdata_r;

  // ----------------------------------------
  // Pins and clock sources
  // ----------------------------------------
  logic clk_lvl;
  logic clk_rise;
  logic clk_fall;
  logic load_lvl;
  logic load_rise;
  logic load_fall;
  logic [TAPS-1:0] tap_en;

  tap_divider #(.TAPS(TAPS)) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tap_en(tap_en)
  );

  pin_edge u_clk_pin (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(count_input_pin),
    .level(clk_lvl),
    .rise(clk_rise),
    .fall(clk_fall)
  );

  pin_edge u_load_pin (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(load_input_pin),
    .level(load_lvl),
    .rise(load_rise),
    .fall(load_fall)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_csc = req.wr && (req.addr == OFS_CSC);
  wire wr_cnt = req.wr && (req.addr == OFS_CNT);
  wire wr_rld = req.wr && (req.addr == OFS_RLD);
  wire wr_iclr = req.wr && (req.addr == OFS_ICLR);
  wire wr_ien = req.wr && (req.addr == OFS_IEN);
  wire rd_csc = req.rd && (req.addr == OFS_CSC);

  // ----------------------------------------
  // Counter clocking and events
  // ----------------------------------------
  wire ext_sel = (sel_r == SEL_EXT_FALL) || (sel_r == SEL_EXT_RISE);
  // Codes past the last tap see zero, so no index leaves the tap vector
  wire [7:0] tap_pad = 8'(tap_en);
  wire tap_tick = !ext_sel && tap_pad[sel_r];
  wire ext_tick = (sel_r == SEL_EXT_RISE) ? clk_rise : clk_fall;
  wire tick = ext_sel ? ext_tick : tap_tick;
  wire load_evt = (pos_en_r && load_rise) || (neg_en_r && load_fall);
  wire roll = tick && (cnt_r == CNT_MAX);
  // A pin load or software write takes the cycle; the tick is dropped
  wire ovf_evt = roll && !load_evt && !wr_cnt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_evt) begin
      cnt_nxt = rld_r;
    end else if (wr_cnt) begin
      cnt_nxt = req.wdata;
    end else if (roll) begin
      cnt_nxt = rld_r;
    end else if (tick) begin
      cnt_nxt = cnt_r + ONE16;
    end
  end

  // ----------------------------------------
  // Overflow flag with read-then-write clear
  // ----------------------------------------
  // Overflow in the gap disarms, and set beats a same-cycle clear
  wire ovf_clr = wr_csc && !req.wdata[B_OVF] && armed_r;

  always_comb begin
    ovf_nxt = ovf_r;
    armed_nxt = armed_r;
    if (ovf_evt) begin
      ovf_nxt = 1'b1;
      armed_nxt = 1'b0;
    end else begin
      if (ovf_clr) begin
        ovf_nxt = 1'b0;
      end
      if (wr_csc) begin
        armed_nxt = 1'b0;
      end else if (rd_csc && ovf_r) begin
        armed_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Local interrupt status: set wins over clear
  // ----------------------------------------
  wire [N_EVT-1:0] evt_vec = {load_evt, ovf_evt};
  wire [N_EVT-1:0] clr_vec = wr_iclr ? req.wdata[N_EVT-1:0] : '0;

  always_comb begin
    istat_nxt = (istat_r & ~clr_vec) | evt_vec;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= CNT_RST;
      ovf_r <= 1'b0;
      armed_r <= 1'b0;
      istat_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
      armed_r <= armed_nxt;
      istat_r <= istat_nxt;
    end
  end

  // Pin level bits 7:6 have no storage, so writes cannot touch them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      il_r <= IL_OFF;
      arb_msb_r <= 1'b0;
      drv_a_r <= 1'b0;
      drv_b_r <= 1'b0;
      neg_en_r <= 1'b0;
      pos_en_r <= 1'b0;
      sel_r <= 3'h0;
    end else if (wr_csc) begin
      il_r <= req.wdata[B_IL_HI:B_IL_LO];
      arb_msb_r <= req.wdata[B_ARB];
      drv_a_r <= req.wdata[B_DRV_A];
      drv_b_r <= req.wdata[B_DRV_B];
      neg_en_r <= req.wdata[B_NEG];
      pos_en_r <= req.wdata[B_POS];
      sel_r <= req.wdata[B_SEL_HI:B_SEL_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rld_r <= RLD_RST;
      ien_r <= '0;
    end else begin
      if (wr_rld) begin
        rld_r <= req.wdata;
      end
      if (wr_ien) begin
        ien_r <= req.wdata[N_EVT-1:0];
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [15:0] csc_view = {ovf_r, il_r, arb_msb_r, 1'b0, drv_a_r, drv_b_r,
                          clk_lvl, load_lvl, neg_en_r, pos_en_r, 1'b0, sel_r};
  wire [15:0] istat_view = {{(16-N_EVT){1'b0}}, istat_r};
  wire [15:0] ien_view = {{(16-N_EVT){1'b0}}, ien_r};
  // Clear register is write-only and the spare slot is reserved
  wire [15:0] rd_mux =
    (req.addr == OFS_CSC) ? csc_view :
    (req.addr == OFS_CNT) ? cnt_r :
    (req.addr == OFS_RLD) ? rld_r :
    (req.addr == OFS_ISTAT) ? istat_view :
    (req.addr == OFS_IEN) ? ien_view : ZERO16;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= ZERO16;
    end else if (req.rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= ZERO16;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = rdata_r;
  assign tbb_a_val = cnt_r;
  assign tbb_b_val = cnt_r;
  assign tbb_a_drv = drv_a_r;
  assign tbb_b_drv = drv_b_r;
  assign arbitration_id = {arb_msb_r, arb_id_low};
  assign imb_irq_req = ovf_r && (il_r != IL_OFF);
  assign imb_irq_level = il_r;
  assign irq = |(istat_r & ien_r);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ovf_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    ovf_evt |=> (cnt_r == $past(rld_r)) && ovf_r)
    else $error("overflow did not reload or flag");

  a_ovf_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ovf_r && !$past(ovf_r) && rd_csc) ##1 (ovf_evt && wr_csc) |=> ovf_r)
    else $error("overflow flag lost to a clear");

  a_ovf_cleared: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_csc && ovf_r ##1 wr_csc && !req.wdata[B_OVF] && !ovf_evt |=> !ovf_r)
    else $error("overflow flag not cleared");

  a_ovf_gap_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_csc && ovf_r ##1 !req.wr && !ovf_evt ##1 wr_csc && !req.wdata[B_OVF] && !ovf_evt
    |=> !ovf_r)
    else $error("overflow flag not cleared after a gap");

  a_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    imb_irq_req == (ovf_r && (il_r != IL_OFF)))
    else $error("interrupt request disagrees with flag and level");

  a_load_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
    load_evt |=> cnt_r == $past(rld_r) ##0 istat_r[EVT_LOAD])
    else $error("load edge did not reload");

  a_ext_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sel_r == SEL_EXT_RISE) && clk_rise && !roll && !load_evt && !wr_cnt
    |=> cnt_r == $past(cnt_r) + ONE16)
    else $error("rising pin edge not counted");

  a_pin_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_csc |=> rdata[B_CLK_LVL] == $past(clk_lvl) && rdata[B_LOAD_LVL] == $past(load_lvl))
    else $error("pin level bits wrong");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    req.rd && (req.addr == OFS_RSV || req.addr == OFS_ICLR) |=> rdata == ZERO16)
    else $error("reserved location read nonzero");

  a_drive_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_csc |=> tbb_a_drv == $past(req.wdata[B_DRV_A]) && tbb_b_drv == $past(req.wdata[B_DRV_B]))
    else $error("drive bits not applied");

  a_arb_id: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_csc |=> arbitration_id[3] == $past(req.wdata[B_ARB]))
    else $error("arbitration id bit not applied");

  a_cnt_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_cnt && !load_evt |=> cnt_r == $past(req.wdata))
    else $error("counter write not taken");
endmodule : modulus_counter

// >>> tb/pin_source.sv
/*
  Far-side pin source: drives the count and load pins of the counter.
  Assumes the bench calls its tasks and that one core clock is shared.
*/
`timescale 1ns/1ps
module pin_source (
  // Clock
  input wire logic core_clk,
  // Pins
  output logic count_input_pin,
  output logic load_input_pin
);
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  initial begin
    count_input_pin = 1'b0;
    load_input_pin = 1'b0;
  end

  // Four cycles per level keeps pin changes no faster than a quarter of core clock
  task automatic count_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge core_clk);
      count_input_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      count_input_pin <= 1'b0;
    end
  endtask : count_pulses

  task automatic set_levels(input logic c, input logic l);
    @(posedge core_clk);
    count_input_pin <= c;
    load_input_pin <= l;
  endtask : set_levels
endmodule : pin_source

// >>> tb/modulus_counter_tb.sv
/*
  Self-checking bench for the modulus counter over its strobe register port.
  Assumes the pin source model drives both pins; one 10 MHz clock.
*/
`timescale 1ns/1ps
module modulus_counter_tb
  import mcount_pkg::*;
;
  logic core_clk;
  logic rst_n;
  reg_req_s req;
  logic [DATA_W-1:0] rdata;
  logic count_input_pin, load_input_pin;
  logic [15:0] tbb_a_val, tbb_b_val, d;
  logic tbb_a_drv, tbb_b_drv, imb_irq_req, irq;
  logic [2:0] arb_id_low, imb_irq_level;
  logic [3:0] arbitration_id;
  int num_errors, num_checks, cycles;

  // ----------------------------------------
  // Clock, instances, timeout
  // ----------------------------------------
  always #50 core_clk = ~core_clk;

  modulus_counter u_modulus_counter (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .count_input_pin(count_input_pin), .load_input_pin(load_input_pin),
    .tbb_a_val(tbb_a_val), .tbb_a_drv(tbb_a_drv), .tbb_b_val(tbb_b_val),
    .tbb_b_drv(tbb_b_drv), .arb_id_low(arb_id_low), .imb_irq_req(imb_irq_req),
    .imb_irq_level(imb_irq_level), .arbitration_id(arbitration_id), .irq(irq));

  pin_source u_pin_source (.core_clk(core_clk), .count_input_pin(count_input_pin),
    .load_input_pin(load_input_pin));

  // Whole run needs under two thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------
  // Bus tasks and compare
  // ----------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask : rchk

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    arb_id_low = 3'h5;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (3) @(posedge core_clk);
    #1 chk("cnt in reset", 16'h0000, tbb_a_val);
    @(posedge core_clk);
    rst_n <= 1'b1;
    rchk("csc reset", OFS_CSC, 16'h0000);
    $display("test reset done");
    // Pins high, every writable bit set
    u_pin_source.set_levels(1'b1, 1'b1);
    wr(OFS_CSC, 16'hffff);
    rchk("csc all", OFS_CSC, 16'h7bf7);
    chk("irq level", 16'h0007, {13'h0, imb_irq_level});
    chk("arb id", 16'h000d, {12'h0, arbitration_id});
    wr(OFS_CSC, 16'h0007);
    rchk("pins ro", OFS_CSC, 16'h00c7);
    chk("arb id low", 16'h0005, {12'h0, arbitration_id});
    u_pin_source.set_levels(1'b0, 1'b0);
    repeat (3) @(posedge core_clk);
    rchk("pins low", OFS_CSC, 16'h0007);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CSC, (16'(k) << 8) | 16'h0007);
      chk("drive", 16'(k), {14'h0, tbb_a_drv, tbb_b_drv});
    end
    $display("test fields done");
    wr(OFS_RSV, 16'ha5a5);
    rchk("rsv", OFS_RSV, 16'h0000);
    rchk("clr reg", OFS_ICLR, 16'h0000);
    rchk("unmapped", 4'he, 16'h0000);
    wr(OFS_RLD, 16'h1234);
    rchk("reload", OFS_RLD, 16'h1234);
    wr(OFS_CNT, 16'hbeef);
    rchk("cnt rw", OFS_CNT, 16'hbeef);
    chk("tbb a val", 16'hbeef, tbb_a_val);
    chk("tbb b val", 16'hbeef, tbb_b_val);
    $display("test map done");
    for (int s = 6; s < 8; s++) begin
      wr(OFS_CSC, 16'(s));
      wr(OFS_CNT, 16'h0000);
      u_pin_source.count_pulses(3);
      repeat (6) @(posedge core_clk);
      rchk("ext count", OFS_CNT, 16'h0003);
    end
    // Divider phase is free, so allow a small window around eight ticks
    for (int k = 0; k < TAPS; k++) begin
      wr(OFS_CSC, 16'h0007);
      wr(OFS_CNT, 16'h0000);
      wr(OFS_CSC, 16'(k));
      repeat (8 << (k + 1)) @(posedge core_clk);
      wr(OFS_CSC, 16'h0007);
      rd(OFS_CNT, d);
      chk("tap ticks", 16'h0001, {15'h0, d >= 16'h0008 && d <= 16'h000a});
    end
    $display("test clocks done");
    wr(OFS_IEN, 16'h0001);
    rchk("ien", OFS_IEN, 16'h0001);
    // Load event from the all-ones write above is still pending
    wr(OFS_ICLR, 16'h0003);
    rchk("istat clr", OFS_ISTAT, 16'h0000);
    wr(OFS_CSC, 16'h3007);
    wr(OFS_CNT, 16'hfffe);
    u_pin_source.count_pulses(2);
    repeat (6) @(posedge core_clk);
    rchk("rollover", OFS_CNT, 16'h1234);
    chk("imb req", 16'h0001, {15'h0, imb_irq_req});
    chk("irq", 16'h0001, {15'h0, irq});
    rchk("istat", OFS_ISTAT, 16'h0001);
    wr(OFS_CSC, 16'h3007);
    rchk("ovf no read", OFS_CSC, 16'hb007);
    wr(OFS_CNT, 16'hffff);
    u_pin_source.count_pulses(1);
    repeat (6) @(posedge core_clk);
    wr(OFS_CSC, 16'h3007);
    rchk("ovf between", OFS_CSC, 16'hb007);
    wr(OFS_CSC, 16'h8007);
    chk("level off", 16'h0000, {15'h0, imb_irq_req});
    rchk("ovf one", OFS_CSC, 16'h8007);
    wr(OFS_CSC, 16'h3007);
    rchk("ovf clear", OFS_CSC, 16'h3007);
    chk("imb req off", 16'h0000, {15'h0, imb_irq_req});
    chk("irq held", 16'h0001, {15'h0, irq});
    wr(OFS_ICLR, 16'h0001);
    chk("irq clr", 16'h0000, {15'h0, irq});
    $display("test overflow done");
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CSC, 16'h0007 | (16'(m) << 4));
      wr(OFS_CNT, 16'h0005);
      u_pin_source.set_levels(1'b0, 1'b1);
      repeat (6) @(posedge core_clk);
      rchk("load rise", OFS_CNT, m[0] ? 16'h1234 : 16'h0005);
      wr(OFS_CNT, 16'h0005);
      u_pin_source.set_levels(1'b0, 1'b0);
      repeat (6) @(posedge core_clk);
      rchk("load fall", OFS_CNT, m[1] ? 16'h1234 : 16'h0005);
    end
    rchk("istat load", OFS_ISTAT, 16'h0002);
    wr(OFS_ICLR, 16'h0002);
    rchk("istat load clr", OFS_ISTAT, 16'h0000);
    $display("test load done");
    results();
  end
endmodule : modulus_counter_tb
